/* File: inc/srst_pkg.sv */
`default_nettype none
package srst_pkg;
	// bus geometry
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 32;
	localparam int CFG_WORDS = 4;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CAUSE     = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CAUSE_CLR = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CAUSE_SET = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_CAUSE_INV = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_SOFT      = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_SOFT_CLR  = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_SOFT_SET  = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_SOFT_INV  = 8'h1c;
	localparam logic [ADDR_W-1:0] OFF_KEY       = 8'h30;

	// reset cause field positions
	localparam int BIT_POR   = 0;
	localparam int BIT_BOR   = 1;
	localparam int BIT_IDLE  = 2;
	localparam int BIT_SLEEP = 3;
	localparam int BIT_WATCHDOG_TIMEOUT_FLAG  = 4;
	localparam int BIT_SWR   = 6;
	localparam int BIT_PIN_RESET_FLAG  = 7;
	localparam int BIT_VREGS = 8;
	localparam int BIT_CMR   = 9;
	localparam int BIT_ARM   = 0;

	// reset values and masks
	localparam logic [DATA_W-1:0] CAUSE_RST  = 32'h0000_0003;
	localparam logic [DATA_W-1:0] CAUSE_MASK = 32'h0000_03df;
	localparam logic [DATA_W-1:0] FLAG_MASK  = 32'h0000_02df;

	// unlock keys
	localparam logic [DATA_W-1:0] KEY_FIRST  = 32'haa99_6655;
	localparam logic [DATA_W-1:0] KEY_SECOND = 32'h5566_99aa;

	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int MASTER_CLEAR_PIN_MIN_NS   = 200;
	localparam int MASTER_CLEAR_PIN_FILT_CYC = (MASTER_CLEAR_PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CPU_DELAY_CYC = 8;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// write flavours
	typedef enum logic [1:0] {OP_WRITE, OP_CLR, OP_SET, OP_INV} srst_op_e;

	// sequencer states
	typedef enum logic [2:0] {ST_CLEAR, ST_LOAD, ST_OSC, ST_DELAY, ST_RUN, ST_HOLD} srst_state_e;
endpackage
`default_nettype wire

/* File: src/srst_master_clear_pin_filt.sv */
`timescale 1ns/1ns
`default_nettype none
module srst_master_clear_pin_filt (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic pin_n,
	output logic      active
);
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic       act_q;
	logic       act_d;

	// pulses shorter than the minimum width never reach the active flag
	always_comb begin
		cnt_d = cnt_q;
		act_d = act_q;
		if (pin_n) begin
			cnt_d = 4'h0;
			act_d = 1'b0;
		end else if (cnt_q >= 4'(srst_pkg::MASTER_CLEAR_PIN_FILT_CYC - 1)) begin
			act_d = 1'b1;
		end else begin
			cnt_d = cnt_q + 4'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 4'h0;
			act_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			act_q <= act_d;
		end
	end

	assign active = act_q;
endmodule
`default_nettype wire

/* File: src/srst_cfg_store.sv */
`timescale 1ns/1ns
`default_nettype none
module srst_cfg_store (
	input  wire logic                                        aclk,
	input  wire logic                                        aresetn,
	input  wire logic                                        clear,
	input  wire logic                                        load,
	input  wire logic                                        upset,
	input  wire logic [srst_pkg::CFG_WORDS*srst_pkg::DATA_W-1:0] flash_words,
	output logic      [srst_pkg::CFG_WORDS*srst_pkg::DATA_W-1:0] cfg_words,
	output logic                                             mismatch
);
	localparam int W = srst_pkg::DATA_W;
	logic [srst_pkg::CFG_WORDS-1:0] bad;
	logic                           mis_q;

	// each word keeps a complementary background copy beside it
	for (genvar i = 0; i < srst_pkg::CFG_WORDS; i++) begin : g_word
		logic [W-1:0] main_q;
		logic [W-1:0] main_d;
		logic [W-1:0] back_q;
		logic [W-1:0] back_d;
		always_comb begin
			main_d = main_q;
			back_d = back_q;
			if (clear) begin
				main_d = '0;
				back_d = '1;
			end else if (load) begin
				main_d = flash_words[i*W +: W];
				back_d = ~flash_words[i*W +: W];
			end else if (upset && i == 0) begin
				back_d = back_q ^ 32'h0000_0001; // models a disturbed cell
			end
		end
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				main_q <= '0;
				back_q <= '1;
			end else begin
				main_q <= main_d;
				back_q <= back_d;
			end
		end
		assign bad[i] = |(main_q ^ ~back_q);
		assign cfg_words[i*W +: W] = main_q;
	end

	// compare runs every cycle, sleep included
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mis_q <= 1'b0;
		end else begin
			mis_q <= |bad;
		end
	end

	assign mismatch = mis_q;
endmodule
`default_nettype wire

/* File: src/srst_ctrl.sv */
// Behaviour
// - soft reset register: arm at bit 0 reads back, other bits read zero
// - arm writes ignored unless unlock sequence done; software unlocks first
// - soft reset fires only when a read follows the arming write
// - system reset asserts on the cycle after the triggering read
// - all sources merge into one system reset; each sets its own flag
// - reset held until config loaded and clock stable; cpu freed 8 cycles later
// - master clear pin asserts reset once low past the filter width
// - pin reset sets the pin flag at bit 7
// - soft reset sets the soft flag at bit 6, others unchanged
// - watchdog time-out while running resets and sets the watchdog flag
// - watchdog in low power wakes to reset vector, only wdt and mode flags change
// - brown-out resets and sets the brown-out flag at bit 1
// - config words have complement copies, compared always; mismatch resets
// - mismatch reset sets the mismatch flag at bit 9
// - every reset reloads config; only power-on clears it first
// - cause flags are pure status, software sets or clears them freely
// - power-on sets power-on and brown-out; brown-out sets only brown-out
// - pin reset while running sets pin flag, others kept, reset vector
// - pin reset in sleep or idle keeps the mode flag from the wait
// - interrupt wake clears watchdog flag, keeps mode flag, interrupt vector
// - pin, soft, mismatch, wdt, mode flags cleared by power-on, brown-out, software
`timescale 1ns/1ns
`default_nettype none
module srst_ctrl (
	input  wire logic                                            aclk,
	input  wire logic                                            aresetn,
	input  wire logic [srst_pkg::ADDR_W-1:0]                     s_axi_awaddr,
	input  wire logic                                            s_axi_awvalid,
	output logic                                                 s_axi_awready,
	input  wire logic [31:0]                                     s_axi_wdata,
	input  wire logic [3:0]                                      s_axi_wstrb,
	input  wire logic                                            s_axi_wvalid,
	output logic                                                 s_axi_wready,
	output logic [1:0]                                           s_axi_bresp,
	output logic                                                 s_axi_bvalid,
	input  wire logic                                            s_axi_bready,
	input  wire logic [srst_pkg::ADDR_W-1:0]                     s_axi_araddr,
	input  wire logic                                            s_axi_arvalid,
	output logic                                                 s_axi_arready,
	output logic [31:0]                                          s_axi_rdata,
	output logic [1:0]                                           s_axi_rresp,
	output logic                                                 s_axi_rvalid,
	input  wire logic                                            s_axi_rready,
	input  wire logic                                            master_clear_pin_n,
	input  wire logic                                            brownout_in,
	input  wire logic                                            watchdog_timeout,
	input  wire logic                                            wait_sleep,
	input  wire logic                                            wait_idle,
	input  wire logic                                            wake_irq,
	input  wire logic                                            osc_stable,
	input  wire logic                                            cfg_upset,
	input  wire logic [srst_pkg::CFG_WORDS*srst_pkg::DATA_W-1:0] cfg_flash_words,
	output logic [srst_pkg::CFG_WORDS*srst_pkg::DATA_W-1:0]      cfg_words_out,
	output logic                                                 system_reset_out,
	output logic                                                 cpu_reset_out,
	output logic                                                 wake_reset_vector,
	output logic                                                 wake_irq_vector
);
	localparam int W = srst_pkg::DATA_W;

	// sequencer state
	srst_pkg::srst_state_e state_q;
	srst_pkg::srst_state_e state_d;
	logic [3:0]            dly_q;
	logic [3:0]            dly_d;
	logic                  sys_rst_q;
	logic                  sys_rst_d;
	logic                  cpu_rst_q;
	logic                  cpu_rst_d;

	// low-power tracking and wake pulses
	logic lp_sleep_q;
	logic lp_sleep_d;
	logic lp_idle_q;
	logic lp_idle_d;
	logic wk_rst_q;
	logic wk_rst_d;
	logic wk_irq_q;
	logic wk_irq_d;

	// registers
	logic [W-1:0] cause_q;
	logic [W-1:0] cause_d;
	logic         arm_q;
	logic         arm_d;
	logic [1:0]   ul_q;
	logic [1:0]   ul_d;

	// bus slave state
	logic                        awhold_q;
	logic                        awhold_d;
	logic [srst_pkg::ADDR_W-1:0] awaddr_q;
	logic [srst_pkg::ADDR_W-1:0] awaddr_d;
	logic                        whold_q;
	logic                        whold_d;
	logic [W-1:0]                wdata_q;
	logic [W-1:0]                wdata_d;
	logic [3:0]                  wstrb_q;
	logic [3:0]                  wstrb_d;
	logic                        bvalid_q;
	logic                        bvalid_d;
	logic [1:0]                  bresp_q;
	logic [1:0]                  bresp_d;
	logic                        awready_q;
	logic                        awready_d;
	logic                        wready_q;
	logic                        wready_d;
	logic                        arready_q;
	logic                        arready_d;
	logic                        rvalid_q;
	logic                        rvalid_d;
	logic [W-1:0]                rdata_q;
	logic [W-1:0]                rdata_d;
	logic [1:0]                  rresp_q;
	logic [1:0]                  rresp_d;

	// event terms
	logic         master_clear_pin_act;
	logic         cfg_mis;
	logic         running;
	logic         low_power;
	logic         do_wr;
	logic         rd_take;
	logic [W-1:0] wmask;
	logic         swr_ev;
	logic         wdt_rst_ev;
	logic         wdt_wake_ev;
	logic         irq_wake_ev;
	logic         cmr_ev;
	logic         run_rst_ev;

	srst_master_clear_pin_filt u_filt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin_n   (master_clear_pin_n),
		.active  (master_clear_pin_act)
	);

	// config words reloaded on every reset, cleared only after power-on
	srst_cfg_store u_cfg (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.clear       (state_q == srst_pkg::ST_CLEAR),
		.load        (state_q == srst_pkg::ST_LOAD),
		.upset       (cfg_upset),
		.flash_words (cfg_flash_words),
		.cfg_words   (cfg_words_out),
		.mismatch    (cfg_mis)
	);

	// applies one of the four write flavours under a byte mask
	function automatic logic [W-1:0] apply(input srst_pkg::srst_op_e op, input logic [W-1:0] old,
	                                       input logic [W-1:0] wd, input logic [W-1:0] m);
		logic [W-1:0] r;
		r = old;
		unique case (op)
			srst_pkg::OP_WRITE: r = (old & ~m) | (wd & m);
			srst_pkg::OP_CLR:   r = old & ~(wd & m);
			srst_pkg::OP_SET:   r = old | (wd & m);
			srst_pkg::OP_INV:   r = old ^ (wd & m);
		endcase
		return r;
	endfunction

	// byte strobes widened to a bit mask
	for (genvar b = 0; b < 4; b++) begin : g_mask
		assign wmask[b*8 +: 8] = {8{wstrb_q[b]}};
	end

	assign running     = (state_q == srst_pkg::ST_RUN);
	assign low_power   = lp_sleep_q | lp_idle_q;
	assign do_wr       = awhold_q & whold_q & ~bvalid_q;
	assign rd_take     = s_axi_arvalid & arready_q;
	// trigger needs a read of the armed register
	assign swr_ev      = running & rd_take & arm_q & (s_axi_araddr == srst_pkg::OFF_SOFT);
	// watchdog resets only when not in low power
	assign wdt_rst_ev  = running & watchdog_timeout & ~low_power;
	// watchdog in low power becomes a wake, not a reset
	assign wdt_wake_ev = running & watchdog_timeout & low_power;
	assign irq_wake_ev = running & wake_irq & low_power & ~watchdog_timeout;
	// mismatch checked whenever the core runs or sleeps
	assign cmr_ev      = running & cfg_mis;
	assign run_rst_ev  = swr_ev | wdt_rst_ev | cmr_ev;

	// reset sequencer: hold, reload config, wait for clock, then count out the cpu delay
	always_comb begin
		state_d = state_q;
		dly_d   = dly_q;
		// every source but power-on funnels into one hold state; power-on starts in ST_CLEAR
		if (brownout_in | master_clear_pin_act | run_rst_ev) begin
			state_d = srst_pkg::ST_HOLD;
		end else begin
			unique case (state_q)
				srst_pkg::ST_CLEAR: state_d = srst_pkg::ST_LOAD;
				srst_pkg::ST_HOLD:  state_d = srst_pkg::ST_LOAD;
				srst_pkg::ST_LOAD:  state_d = srst_pkg::ST_OSC;
				srst_pkg::ST_OSC: begin
					dly_d = 4'h0;
					if (osc_stable) begin
						state_d = srst_pkg::ST_DELAY;
					end
				end
				// cpu held for the fixed cycle count
				srst_pkg::ST_DELAY: begin
					dly_d = dly_q + 4'h1;
					if (dly_q == 4'(srst_pkg::CPU_DELAY_CYC - 1)) begin
						state_d = srst_pkg::ST_RUN;
					end
				end
				srst_pkg::ST_RUN: state_d = srst_pkg::ST_RUN;
				default:          state_d = srst_pkg::ST_HOLD;
			endcase
		end
		// the reset flop follows the next state, so it rises right after the read
		sys_rst_d = (state_d != srst_pkg::ST_DELAY) && (state_d != srst_pkg::ST_RUN);
		cpu_rst_d = (state_d != srst_pkg::ST_RUN);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q   <= srst_pkg::ST_CLEAR;
			dly_q     <= 4'h0;
			sys_rst_q <= 1'b1;
			cpu_rst_q <= 1'b1;
		end else begin
			state_q   <= state_d;
			dly_q     <= dly_d;
			sys_rst_q <= sys_rst_d;
			cpu_rst_q <= cpu_rst_d;
		end
	end

	// low-power mode entered by a wait, left by a wake or any reset
	always_comb begin
		lp_sleep_d = lp_sleep_q;
		lp_idle_d  = lp_idle_q;
		wk_rst_d   = wdt_wake_ev;
		// interrupt wake branches to the interrupt vector
		wk_irq_d   = irq_wake_ev;
		if (!running || wdt_wake_ev || irq_wake_ev) begin
			lp_sleep_d = 1'b0;
			lp_idle_d  = 1'b0;
		end else if (wait_sleep) begin
			lp_sleep_d = 1'b1;
		end else if (wait_idle) begin
			lp_idle_d = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lp_sleep_q <= 1'b0;
			lp_idle_q  <= 1'b0;
			wk_rst_q   <= 1'b0;
			wk_irq_q   <= 1'b0;
		end else begin
			lp_sleep_q <= lp_sleep_d;
			lp_idle_q  <= lp_idle_d;
			wk_rst_q   <= wk_rst_d;
			wk_irq_q   <= wk_irq_d;
		end
	end

	// register file: software effect first, then hardware clears, then hardware sets
	always_comb begin
		logic [W-1:0] sw;
		logic [W-1:0] hclr;
		logic [W-1:0] hset;
		srst_pkg::srst_op_e op;
		sw   = cause_q;
		hclr = '0;
		hset = '0;
		op   = srst_pkg::srst_op_e'(awaddr_q[3:2]);
		arm_d = arm_q;
		ul_d  = ul_q;
		if (do_wr) begin
			// flags are plain status, any write form is allowed
			if (awaddr_q[7:4] == srst_pkg::OFF_CAUSE[7:4]) begin
				sw = apply(op, cause_q, wdata_q, wmask) & srst_pkg::CAUSE_MASK;
			end
			if (awaddr_q[7:4] == srst_pkg::OFF_SOFT[7:4] && ul_q == 2'h2) begin
				arm_d = apply(op, {31'h0, arm_q}, wdata_q, wmask) != 32'h0;
			end
			// first key then second key, anything else relocks
			if (awaddr_q == srst_pkg::OFF_KEY) begin
				if (wstrb_q == 4'hf && wdata_q == srst_pkg::KEY_FIRST) begin
					ul_d = 2'h1;
				end else if (wstrb_q == 4'hf && wdata_q == srst_pkg::KEY_SECOND && ul_q == 2'h1) begin
					ul_d = 2'h2;
				end else begin
					ul_d = 2'h0;
				end
			end
		end
		// arm and unlock fall away once the system reset applies
		if (sys_rst_q) begin
			arm_d = 1'b0;
			ul_d  = 2'h0;
		end
		// brown-out keeps only its own flag and the VREGS flag
		if (brownout_in) begin
			hclr = srst_pkg::FLAG_MASK;
			hset[srst_pkg::BIT_BOR] = 1'b1;
		end else begin
			// pin reset flag, other flags untouched
			hset[srst_pkg::BIT_PIN_RESET_FLAG] = master_clear_pin_act;
			hset[srst_pkg::BIT_SWR] = swr_ev;
			hset[srst_pkg::BIT_CMR] = cmr_ev;
			// watchdog flag on time-out in either mode
			hset[srst_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = wdt_rst_ev | wdt_wake_ev;
			// mode flags come from the wait itself and survive a pin reset
			hset[srst_pkg::BIT_SLEEP] = running & wait_sleep;
			hset[srst_pkg::BIT_IDLE] = running & wait_idle & ~wait_sleep;
			// interrupt wake drops the watchdog flag
			hclr[srst_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = irq_wake_ev;
		end
		// clears yield to a simultaneous set
		cause_d = (sw & ~hclr) | hset;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// power-on leaves power-on and brown-out set
			cause_q <= srst_pkg::CAUSE_RST;
			arm_q   <= 1'b0;
			ul_q    <= 2'h0;
		end else begin
			cause_q <= cause_d;
			arm_q   <= arm_d;
			ul_q    <= ul_d;
		end
	end

	// bus slave: address and data captured in either order, one write and one read open
	always_comb begin
		awhold_d = awhold_q;
		awaddr_d = awaddr_q;
		whold_d  = whold_q;
		wdata_d  = wdata_q;
		wstrb_d  = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d  = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (s_axi_awvalid && awready_q) begin
			awhold_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			whold_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (do_wr) begin
			awhold_d = 1'b0;
			whold_d  = 1'b0;
			bvalid_d = 1'b1;
			bresp_d  = (awaddr_q[7:4] <= 4'h1 || awaddr_q == srst_pkg::OFF_KEY) ?
			           srst_pkg::RESP_OKAY : srst_pkg::RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (rd_take) begin
			rvalid_d = 1'b1;
			rresp_d  = srst_pkg::RESP_OKAY;
			rdata_d  = '0;
			unique case (s_axi_araddr)
				srst_pkg::OFF_CAUSE: rdata_d = cause_q;
				// only the arm bit shows, upper bits zero
				srst_pkg::OFF_SOFT: rdata_d = {31'h0, arm_q};
				srst_pkg::OFF_CAUSE_CLR, srst_pkg::OFF_CAUSE_SET, srst_pkg::OFF_CAUSE_INV,
				srst_pkg::OFF_SOFT_CLR, srst_pkg::OFF_SOFT_SET, srst_pkg::OFF_SOFT_INV,
				srst_pkg::OFF_KEY: rdata_d = '0;
				default: rresp_d = srst_pkg::RESP_SLVERR;
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		// readies registered so every port comes from a flop
		awready_d = ~awhold_d & ~bvalid_d;
		wready_d  = ~whold_d & ~bvalid_d;
		arready_d = ~rvalid_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awhold_q  <= 1'b0;
			awaddr_q  <= '0;
			whold_q   <= 1'b0;
			wdata_q   <= '0;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= srst_pkg::RESP_OKAY;
			rvalid_q  <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= srst_pkg::RESP_OKAY;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			arready_q <= 1'b0;
		end else begin
			awhold_q  <= awhold_d;
			awaddr_q  <= awaddr_d;
			whold_q   <= whold_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			arready_q <= arready_d;
		end
	end

	// outputs straight from flops
	assign s_axi_awready     = awready_q;
	assign s_axi_wready      = wready_q;
	assign s_axi_bvalid      = bvalid_q;
	assign s_axi_bresp       = bresp_q;
	assign s_axi_arready     = arready_q;
	assign s_axi_rvalid      = rvalid_q;
	assign s_axi_rdata       = rdata_q;
	assign s_axi_rresp       = rresp_q;
	assign system_reset_out  = sys_rst_q;
	assign cpu_reset_out     = cpu_rst_q;
	assign wake_reset_vector = wk_rst_q;
	assign wake_irq_vector   = wk_irq_q;
endmodule
`default_nettype wire

/* File: testbench/srst_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module srst_properties (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        master_clear_pin_n,
	input wire logic        brownout_in,
	input wire logic        cfg_upset,
	input wire logic        system_reset_out,
	input wire logic        cpu_reset_out,
	input wire logic        wake_reset_vector,
	input wire logic        wake_irq_vector
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// read request taken, then a soft register read answering armed
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence arm_read;
		rd_take ##0 s_axi_araddr == srst_pkg::OFF_SOFT ##1 s_axi_rdata[0];
	endsequence

	// pin, brown-out, soft and mismatch resets reach the system reset within a fixed bound
	AST_CPU_DELAY: assert property ($fell(system_reset_out) |-> cpu_reset_out [*8] ##1 !cpu_reset_out)
		else $error("bad cpu release");
	AST_SOFT_NEXT: assert property (arm_read |-> system_reset_out)
		else $error("soft reset late");
	AST_PIN_RESET: assert property (!master_clear_pin_n [*3] |-> ##[0:2] system_reset_out)
		else $error("pin reset missing");
	AST_BROWNOUT: assert property (brownout_in |-> ##[1:2] system_reset_out)
		else $error("brown-out reset missing");
	AST_MISMATCH: assert property (cfg_upset && !cpu_reset_out |-> ##[1:3] system_reset_out)
		else $error("mismatch reset missing");
	AST_WDT_WAKE: assert property (wake_reset_vector |-> !system_reset_out ##1 !system_reset_out)
		else $error("watchdog wake reset");
	AST_IRQ_WAKE: assert property (wake_irq_vector |-> !system_reset_out ##1 !cpu_reset_out)
		else $error("interrupt wake reset");
	AST_RD_ANSWER: assert property (rd_take |=> s_axi_rvalid)
		else $error("read answer late");
endmodule
bind srst_ctrl srst_properties u_props (.*);
`default_nettype wire

/* File: testbench/srst_env.sv */
`timescale 1ns/1ns
`default_nettype none
module srst_env (
	input  wire logic    aclk,
	input  wire logic    aresetn,
	input  wire logic    slow,
	output logic         osc_stable,
	output logic [127:0] cfg_flash_words
);
	logic [3:0] cnt_q;
	// oscillator settles only after power-on; slow crystal keeps the hold long
	always_ff @(posedge aclk) begin
		if (!aresetn) cnt_q <= 4'h0;
		else if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
	end
	assign osc_stable = cnt_q >= (slow ? 4'hc : 4'h2);
	// flash image, a distinct pattern per word
	assign cfg_flash_words = {32'h0f0f_a5a5, 32'h1234_5678, 32'hc3c3_3c3c, 32'h0000_ffff};
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic         aclk = 1'h0, aresetn = 1'h0, slow = 1'h1, wait_idle = 1'h0;
	logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]   s_axi_wstrb = 4'hf;
	logic [1:0]   s_axi_bresp, s_axi_rresp;
	logic         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic         s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [5:0]   pls = 6'h00;
	logic         master_clear_pin_n, brownout_in, watchdog_timeout, wait_sleep, wake_irq, cfg_upset;
	logic         osc_stable, system_reset_out, cpu_reset_out, wake_reset_vector, wake_irq_vector;
	logic [127:0] cfg_flash_words, cfg_words_out;
	int           n_fail = 0, n_tests = 0, cyc = 0;

	// pulse inputs share one vector so one task drives them all
	assign master_clear_pin_n = ~pls[0];
	assign brownout_in = pls[1];
	assign watchdog_timeout = pls[2];
	assign wait_sleep = pls[3];
	assign wake_irq = pls[4];
	assign cfg_upset = pls[5];

	srst_env  u_env (.*);
	srst_ctrl u_dut (.*);

	always #50 aclk = ~aclk;

	// hang guard, far above the few hundred cycles needed
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			end_of_test;
		end
	end

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		chk(s_axi_bresp, srst_pkg::RESP_OKAY);
	endtask

	// unmapped places above the soft register answer with an error
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		chk(s_axi_rresp, (a > 8'h1c && a != srst_pkg::OFF_KEY) ? srst_pkg::RESP_SLVERR : srst_pkg::RESP_OKAY);
		chk(s_axi_rdata, exp);
	endtask

	task automatic pl(input int i, input int n);
		@(posedge aclk);
		pls[i] <= 1'h1;
		repeat (n) @(posedge aclk);
		pls[i] <= 1'h0;
	endtask

	// wait through a whole reset until the cpu runs again
	task automatic run;
		wait (cpu_reset_out === 1'h1);
		wait (cpu_reset_out === 1'h0);
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		run;
		rd(srst_pkg::OFF_CAUSE, 32'h3);
		rd(srst_pkg::OFF_SOFT, 32'h0);
		wr(srst_pkg::OFF_CAUSE_SET, 32'h80);
		rd(srst_pkg::OFF_CAUSE, 32'h83);
		wr(srst_pkg::OFF_CAUSE_CLR, 32'hffff_ffff);
		rd(srst_pkg::OFF_CAUSE, 32'h0);
		wr(srst_pkg::OFF_SOFT, 32'h1);
		rd(srst_pkg::OFF_SOFT, 32'h0);
		wr(srst_pkg::OFF_KEY, srst_pkg::KEY_FIRST);
		wr(srst_pkg::OFF_KEY, srst_pkg::KEY_SECOND);
		wr(srst_pkg::OFF_SOFT_SET, 32'h1);
		rd(srst_pkg::OFF_SOFT, 32'h1);
		chk(system_reset_out, 1'h1);
		// no further access until the reset has passed
		run;
		rd(srst_pkg::OFF_SOFT, 32'h0);
		rd(srst_pkg::OFF_CAUSE, 32'h40);
		rd(8'h20, 32'h0);
		// a one-cycle dip on the pin must be filtered out
		pl(0, 1);
		rd(srst_pkg::OFF_CAUSE, 32'h40);
		pl(0, 3);
		run;
		rd(srst_pkg::OFF_CAUSE, 32'hc0);
		pl(2, 1);
		run;
		rd(srst_pkg::OFF_CAUSE, 32'hd0);
		wr(srst_pkg::OFF_CAUSE_CLR, 32'hffff_ffff);
		pl(3, 1);
		pl(2, 1);
		@(negedge aclk) chk(wake_reset_vector, 1'h1);
		rd(srst_pkg::OFF_CAUSE, 32'h18);
		pl(3, 1);
		pl(4, 1);
		@(negedge aclk) chk(wake_irq_vector, 1'h1);
		rd(srst_pkg::OFF_CAUSE, 32'h08);
		pl(5, 1);
		run;
		rd(srst_pkg::OFF_CAUSE, 32'h208);
		chk(cfg_words_out, cfg_flash_words);
		pl(1, 4);
		run;
		rd(srst_pkg::OFF_CAUSE, 32'h2);
		chk(cfg_words_out, cfg_flash_words);
		// idle entered by a wait, then a pin reset must keep the idle flag
		@(posedge aclk) wait_idle <= 1'h1;
		@(posedge aclk) wait_idle <= 1'h0;
		pl(0, 3);
		run;
		rd(srst_pkg::OFF_CAUSE, 32'h86);
		end_of_test;
	end
endmodule
`default_nettype wire
